// ---- hw/pldc_cfg.svh ----
`ifndef PLDC_CFG_SVH
`define PLDC_CFG_SVH

// Register offsets (byte addresses)
`define PLDC_ADDR_CTRL      12'h000
`define PLDC_ADDR_TOL_BASE  12'h010
`define PLDC_ADDR_CAP_BASE  12'h020
`define PLDC_ADDR_LOAD_BASE 12'h030
`define PLDC_ADDR_REV_BASE  12'h040
`define PLDC_ADDR_TGT_BASE  12'h050
`define PLDC_ADDR_DISP      12'h060
`define PLDC_ADDR_STATUS    12'h064
`define PLDC_ADDR_RATE      12'h068
`define PLDC_ADDR_BENCH_BASE 12'h070

// Control register fields
`define PLDC_CTRL_MULTI_BIT  0
`define PLDC_CTRL_RECALL_BIT 1
`define PLDC_CTRL_RESET      32'h0000_0000

// Tolerance code: 0 is off, 1..9 are 5..45 percent
`define PLDC_TOL_STEP        8'h05
`define PLDC_TOL_MAX_CODE    4'h9
`define PLDC_TOL_HI_LSB      4
`define PLDC_TOL_RESET       8'h00

// Stroke rate: 60 s at 100 MHz, counted per minute
`define PLDC_CLK_HZ          64'd100_000_000
`define PLDC_SEC_PER_MIN     64'd60
`define PLDC_CYC_PER_MIN     (`PLDC_CLK_HZ * `PLDC_SEC_PER_MIN)
`define PLDC_MIN_STROKES     2'h2

// Deviation lamp column: bit 0 bottom red, bit 4 center, bit 8 top red
`define PLDC_LAMP_CENTER     9'h010
`define PLDC_LAMP_OFF        9'h000
`define PLDC_LAMP_TOP        9'h100
`define PLDC_LAMP_BOTTOM     9'h001

`endif

// ---- hw/pldc_pkg.sv ----
package pldc_pkg;
    typedef enum logic [1:0] {
        PLDC_KEY_SETUP,
        PLDC_KEY_MON_NORESET,
        PLDC_KEY_MON_RESET,
        PLDC_KEY_ILLEGAL
    } pldc_key_type;

    typedef enum logic [2:0] {
        PLDC_SHOW_TOTAL,
        PLDC_SHOW_CAP,
        PLDC_SHOW_TOL,
        PLDC_SHOW_REV,
        PLDC_SHOW_TGT,
        PLDC_SHOW_RATE
    } pldc_show_type;

    typedef enum logic {
        PLDC_ST_IDLE,
        PLDC_ST_ARMED
    } pldc_state_type;
endpackage : pldc_pkg

// ---- hw/pldc_lamp_column.sv ----
`include "pldc_cfg.svh"

// One deviation lamp column, fed only by its own channel's comparison
module pldc_lamp_column
    import pldc_pkg::*;
(
    // Channel comparison
    input  wire logic [15:0] bench_in,
    input  wire logic [15:0] peak_in,
    input  wire logic [3:0]  hi_code_in,
    input  wire logic [3:0]  lo_code_in,
    // Result
    output logic      [8:0]  lamps_out,
    output logic             alarm_out
);
    logic [23:0] hi_lim;
    logic [23:0] lo_lim;
    logic [23:0] dev_up;
    logic [23:0] dev_dn;
    logic [23:0] peak_x;
    logic [23:0] bench_x;
    logic        hi_on;
    logic        lo_on;
    logic        over;
    logic        under;
    logic [1:0]  step_up;
    logic [1:0]  step_dn;

    function automatic logic [23:0] pct_of(input logic [15:0] v, input logic [3:0] code);
        logic [23:0] p;
        p = 24'(v) * 24'(code) * 24'(`PLDC_TOL_STEP);
        return 24'(p / 24'h64);
    endfunction : pct_of

    function automatic logic [1:0] step_of(input logic [23:0] dev, input logic [23:0] lim);
        logic [1:0] s;
        s = 2'h0;
        if (dev != 24'h0) begin
            if (dev * 24'h4 >= lim * 24'h3) begin
                s = 2'h3;
            end else if (dev * 24'h2 >= lim) begin
                s = 2'h2;
            end else begin
                s = 2'h1;
            end
        end
        return s;
    endfunction : step_of

    assign peak_x  = 24'(peak_in);
    assign bench_x = 24'(bench_in);
    assign hi_on   = hi_code_in != 4'h0 && hi_code_in <= `PLDC_TOL_MAX_CODE;
    assign lo_on   = lo_code_in != 4'h0 && lo_code_in <= `PLDC_TOL_MAX_CODE;
    assign hi_lim  = pct_of(bench_in, hi_code_in);
    assign lo_lim  = pct_of(bench_in, lo_code_in);
    assign dev_up  = (peak_x > bench_x) ? peak_x - bench_x : 24'h0;
    assign dev_dn  = (peak_x < bench_x) ? bench_x - peak_x : 24'h0;
    assign over    = hi_on && dev_up != 24'h0 && dev_up >= hi_lim;  // RULE8 RULE19
    assign under   = lo_on && dev_dn != 24'h0 && dev_dn >= lo_lim;  // RULE9 RULE19
    assign step_up = step_of(dev_up, hi_on ? hi_lim : 24'hff_ffff);
    assign step_dn = step_of(dev_dn, lo_on ? lo_lim : 24'hff_ffff);
    assign alarm_out = over || under;

    always_comb begin
        if (over) begin
            lamps_out = `PLDC_LAMP_TOP;  // RULE8
        end else if (under) begin
            lamps_out = `PLDC_LAMP_BOTTOM;  // RULE9
        end else if (step_up != 2'h0) begin
            lamps_out = `PLDC_LAMP_CENTER << step_up;  // RULE10
        end else if (step_dn != 2'h0) begin
            lamps_out = `PLDC_LAMP_CENTER >> step_dn;  // RULE10
        end else begin
            lamps_out = `PLDC_LAMP_CENTER;  // RULE7
        end
    end
endmodule : pldc_lamp_column

// ---- hw/pldc_display_ctrl.sv ----
// The APB slave port and the register addresses were chosen for this implementation.
`include "pldc_cfg.svh"

// How it works
// RULE1 - With no display button held, center meter shows total force of all channels.
// RULE2 - Single-meter units show capacity and tolerances on center meter, one channel.
// RULE3 - Multi-meter units drive per-channel meters alongside the center total.
// RULE4 - Each channel has its own lamp column, fed only by its own comparison.
// RULE5 - Entering monitoring samples a benchmark per channel; limits follow from it.
// RULE6 - After sampling, only center lamps light until the next part is formed.
// RULE7 - Load equal to benchmark lights the center lamp alone.
// RULE8 - Force above the high limit lights the column's top red lamp.
// RULE9 - Force below the low limit lights the column's bottom red lamp.
// RULE10 - In-band deviations light caution lamps stepping outward as deviation grows.
// RULE11 - Alarm reset clears alarms only in setup or monitor with reset active.
// RULE12 - Holding capacity button shows each channel's capacity limit in any mode.
// RULE13 - Single-meter settings show only with settings and channel select held.
// RULE14 - Stroke rate in monitoring only, shown on held button after two strokes.
// RULE15 - Tolerance display: high percent in upper two digits, low in lower two.
// RULE16 - Reverse button in monitoring shows snap-through force per channel and total.
// RULE17 - Target button with job recall shows stored targets per channel and total.
// RULE18 - Tolerance selectors give 5 percent steps to 45 percent, plus off.
// RULE19 - Deviation at or beyond a limit raises an alarm and machine stop.
// RULE20 - Moving the keyswitch to setup discards all benchmark samples.
// RULE21 - Stroke rate comes from time between stroke-complete events, refreshed each stroke.
// RULE22 - Simultaneous buttons: one quantity by fixed priority; total once released.
module pldc_display_ctrl
    import pldc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Operator panel pins
    input  wire logic [1:0]  key_pos_in,
    input  wire logic        btn_reset_in,
    input  wire logic        btn_cap_in,
    input  wire logic        btn_tol_in,
    input  wire logic        btn_rate_in,
    input  wire logic        btn_rev_in,
    input  wire logic        btn_tgt_in,
    input  wire logic [3:0]  btn_chan_in,
    // Measurement side, same clock
    input  wire logic        stroke_done_in,
    input  wire logic [63:0] peak_load_in,
    input  wire logic [63:0] rev_load_in,
    // Displays and lamps
    output logic      [17:0] center_meter_out,
    output logic      [63:0] chan_meter_out,
    output logic      [35:0] lamps_out,
    output logic             machine_stop_out,
    output logic             peak_reset_out
);
    localparam int NCH = 4;

    // Synchronisers for panel pins
    logic [11:0] pin_s1_q;
    logic [11:0] pin_s2_q;
    logic [1:0]  key_s3_q;
    logic [1:0]  key_q;
    // Software registers
    logic [31:0] ctrl_q;
    logic [7:0]  tol_q   [NCH];
    logic [15:0] cap_q   [NCH];
    logic [15:0] tgt_q   [NCH];
    // Block state
    logic [15:0] bench_q [NCH];
    logic [15:0] last_q  [NCH];
    pldc_state_type state_q;
    logic        fresh_q;
    logic        alarm_q;
    logic [1:0]  key_prev_q;
    logic [1:0]  strokes_q;
    logic [31:0] gap_q;
    logic [15:0] rate_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [17:0] center_q;
    logic [63:0] chan_q;
    logic [35:0] lamps_q;
    logic        stop_q;
    logic        preset_q;

    // Decoded wires
    logic [1:0]  key_s;
    logic        b_reset;
    logic        b_cap;
    logic        b_tol;
    logic        b_rate;
    logic        b_rev;
    logic        b_tgt;
    logic [3:0]  b_chan;
    logic        monitoring;
    logic        enter_mon;
    logic        enter_setup;
    logic        reset_ok;
    logic        do_reset;
    logic        multi;
    logic        recall;
    logic        wr_en;
    logic        rd_en;
    logic [1:0]  idx;
    logic [35:0] col_lamps;
    logic [3:0]  col_alarm;
    logic        any_alarm;
    pldc_show_type show;
    logic [1:0]  sel_ch;
    logic        sel_any;
    logic [17:0] total_peak;
    logic [17:0] total_rev;
    logic [17:0] total_tgt;
    logic [17:0] center_d;
    logic [63:0] chan_d;
    logic [31:0] rd_d;
    logic        rd_hit;

    function automatic logic [17:0] sum4(input logic [63:0] v);
        return 18'(v[15:0]) + 18'(v[31:16]) + 18'(v[47:32]) + 18'(v[63:48]);
    endfunction : sum4

    function automatic logic [7:0] pct2(input logic [3:0] code);
        logic [7:0] p;
        p = (code <= `PLDC_TOL_MAX_CODE) ? 8'(code) * `PLDC_TOL_STEP : 8'h00;  // RULE18
        return 8'(((p / 8'd10) << 4) | (p % 8'd10));
    endfunction : pct2

    // Panel pins come from outside the clock domain
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pin_s1_q <= 12'h000;
            pin_s2_q <= 12'h000;
            key_s3_q <= PLDC_KEY_SETUP;
            key_q    <= PLDC_KEY_SETUP;
        end else begin
            pin_s1_q <= {btn_chan_in, btn_tgt_in, btn_rev_in, btn_rate_in,
                         btn_tol_in, btn_cap_in, btn_reset_in, key_pos_in};
            pin_s2_q <= pin_s1_q;
            key_s3_q <= pin_s2_q[1:0];
            // Key bits may cross on different edges; take a code only when
            // two samples agree, so a two-bit move never shows a false setup
            if (pin_s2_q[1:0] == key_s3_q) begin
                key_q <= key_s3_q;
            end
        end
    end

    assign key_s       = key_q;
    assign b_reset     = pin_s2_q[2];
    assign b_cap       = pin_s2_q[3];
    assign b_tol       = pin_s2_q[4];
    assign b_rate      = pin_s2_q[5];
    assign b_rev       = pin_s2_q[6];
    assign b_tgt       = pin_s2_q[7];
    assign b_chan      = pin_s2_q[11:8];
    assign monitoring  = key_s == PLDC_KEY_MON_NORESET || key_s == PLDC_KEY_MON_RESET;
    assign enter_mon   = monitoring && key_prev_q == PLDC_KEY_SETUP;
    assign enter_setup = key_s == PLDC_KEY_SETUP && key_prev_q != PLDC_KEY_SETUP;
    assign reset_ok    = key_s == PLDC_KEY_SETUP || key_s == PLDC_KEY_MON_RESET;  // RULE11
    assign do_reset    = b_reset && reset_ok;  // RULE11
    assign multi       = ctrl_q[`PLDC_CTRL_MULTI_BIT];
    assign recall      = ctrl_q[`PLDC_CTRL_RECALL_BIT];

    // APB decode
    assign wr_en = psel_in && penable_in && pwrite_in && !pready_q;
    assign rd_en = psel_in && penable_in && !pwrite_in && !pready_q;
    assign idx   = paddr_in[3:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_d   = 32'h0000_0000;
        unique casez (paddr_in)
            `PLDC_ADDR_CTRL:   rd_d = ctrl_q;
            `PLDC_ADDR_DISP:   rd_d = 32'(center_q);
            `PLDC_ADDR_STATUS: rd_d = {29'h0, state_q, alarm_q, stop_q};
            `PLDC_ADDR_RATE:   rd_d = {14'h0, strokes_q, rate_q};
            default: begin
                unique case (paddr_in & 12'hff0)
                    `PLDC_ADDR_TOL_BASE:   rd_d = 32'(tol_q[idx]);
                    `PLDC_ADDR_CAP_BASE:   rd_d = 32'(cap_q[idx]);
                    `PLDC_ADDR_LOAD_BASE:  rd_d = 32'(last_q[idx]);
                    `PLDC_ADDR_REV_BASE:   rd_d = 32'(rev_load_in[16*idx +: 16]);
                    `PLDC_ADDR_TGT_BASE:   rd_d = 32'(tgt_q[idx]);
                    `PLDC_ADDR_BENCH_BASE: rd_d = 32'(bench_q[idx]);
                    default:               rd_hit = 1'b0;
                endcase
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            ctrl_q    <= `PLDC_CTRL_RESET;
        end else begin
            pready_q  <= psel_in && penable_in && !pready_q;
            pslverr_q <= (wr_en || rd_en) && !rd_hit;
            prdata_q  <= rd_en ? rd_d : 32'h0000_0000;
            if (wr_en && paddr_in == `PLDC_ADDR_CTRL) begin
                ctrl_q <= pwdata_in & 32'h0000_0003;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst_in) begin
                tol_q[i] <= `PLDC_TOL_RESET;
                cap_q[i] <= 16'h0000;
                tgt_q[i] <= 16'h0000;
            end else if (wr_en && idx == 2'(i)) begin
                if ((paddr_in & 12'hff0) == `PLDC_ADDR_TOL_BASE) begin
                    tol_q[i] <= pwdata_in[7:0];
                end
                if ((paddr_in & 12'hff0) == `PLDC_ADDR_CAP_BASE) begin
                    cap_q[i] <= pwdata_in[15:0];
                end
                if ((paddr_in & 12'hff0) == `PLDC_ADDR_TGT_BASE) begin
                    tgt_q[i] <= pwdata_in[15:0];
                end
            end
        end
    end

    // Lamp columns, one per channel
    for (genvar g = 0; g < NCH; g++) begin : g_col
        pldc_lamp_column u_col (
            .bench_in   (bench_q[g]),
            .peak_in    (last_q[g]),
            .hi_code_in (tol_q[g][7:`PLDC_TOL_HI_LSB]),
            .lo_code_in (tol_q[g][3:0]),
            .lamps_out  (col_lamps[9*g +: 9]),  // RULE4
            .alarm_out  (col_alarm[g])
        );
    end
    assign any_alarm = |col_alarm;

    // Benchmark sampling, trend state, alarm latch
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q    <= PLDC_ST_IDLE;
            fresh_q    <= 1'b0;
            alarm_q    <= 1'b0;
            key_prev_q <= PLDC_KEY_SETUP;
            for (int i = 0; i < NCH; i++) begin
                bench_q[i] <= 16'h0000;
                last_q[i]  <= 16'h0000;
            end
        end else begin
            key_prev_q <= key_s;
            if (enter_setup || !monitoring) begin
                state_q <= PLDC_ST_IDLE;  // RULE20
                fresh_q <= 1'b0;
                for (int i = 0; i < NCH; i++) begin
                    bench_q[i] <= 16'h0000;  // RULE20
                end
            end else if (enter_mon) begin
                state_q <= PLDC_ST_ARMED;
                fresh_q <= 1'b1;  // RULE6
                for (int i = 0; i < NCH; i++) begin
                    bench_q[i] <= peak_load_in[16*i +: 16];  // RULE5
                    last_q[i]  <= peak_load_in[16*i +: 16];
                end
            end else if (stroke_done_in && state_q == PLDC_ST_ARMED) begin
                fresh_q <= 1'b0;
                for (int i = 0; i < NCH; i++) begin
                    last_q[i] <= peak_load_in[16*i +: 16];
                end
            end
            if (state_q == PLDC_ST_ARMED && !fresh_q && any_alarm) begin
                alarm_q <= 1'b1;  // RULE19
            end else if (do_reset) begin
                alarm_q <= 1'b0;  // RULE11
            end
        end
    end

    // Stroke rate from stroke-to-stroke interval
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            strokes_q <= 2'h0;
            gap_q     <= 32'h0000_0000;
            rate_q    <= 16'h0000;
        end else if (!monitoring) begin
            strokes_q <= 2'h0;  // RULE14
            gap_q     <= 32'h0000_0000;
        end else begin
            gap_q <= gap_q + 32'h1;
            if (stroke_done_in) begin
                gap_q <= 32'h1;
                if (strokes_q != `PLDC_MIN_STROKES) begin
                    strokes_q <= strokes_q + 2'h1;
                end
                if (strokes_q != 2'h0) begin
                    rate_q <= 16'(`PLDC_CYC_PER_MIN / gap_q);  // RULE21
                end
            end
        end
    end

    // Display selection by fixed priority
    assign sel_any = |b_chan;
    assign sel_ch  = b_chan[0] ? 2'd0 : b_chan[1] ? 2'd1 : b_chan[2] ? 2'd2 : 2'd3;
    always_comb begin
        if (b_cap && (multi || sel_any)) begin
            show = PLDC_SHOW_CAP;  // RULE12 RULE13 RULE22
        end else if (b_tol && (multi || sel_any)) begin
            show = PLDC_SHOW_TOL;  // RULE13 RULE22
        end else if (b_rev && monitoring) begin
            show = PLDC_SHOW_REV;  // RULE16 RULE22
        end else if (b_tgt && recall) begin
            show = PLDC_SHOW_TGT;  // RULE17 RULE22
        end else if (b_rate && monitoring && strokes_q == `PLDC_MIN_STROKES) begin
            show = PLDC_SHOW_RATE;  // RULE14 RULE22
        end else begin
            show = PLDC_SHOW_TOTAL;  // RULE1 RULE22
        end
    end

    assign total_peak = sum4({last_q[3], last_q[2], last_q[1], last_q[0]});
    assign total_rev  = sum4(rev_load_in);
    assign total_tgt  = sum4({tgt_q[3], tgt_q[2], tgt_q[1], tgt_q[0]});

    always_comb begin
        center_d = total_peak;  // RULE1
        chan_d   = {last_q[3], last_q[2], last_q[1], last_q[0]};  // RULE3
        unique case (show)
            PLDC_SHOW_CAP: begin
                chan_d = {cap_q[3], cap_q[2], cap_q[1], cap_q[0]};
                if (!multi) begin
                    center_d = 18'(cap_q[sel_ch]);  // RULE2
                end
            end
            PLDC_SHOW_TOL: begin
                for (int i = 0; i < NCH; i++) begin
                    chan_d[16*i +: 16] = {pct2(tol_q[i][7:4]), pct2(tol_q[i][3:0])};  // RULE15
                end
                if (!multi) begin
                    center_d = 18'(chan_d[16*sel_ch +: 16]);  // RULE2
                end
            end
            PLDC_SHOW_REV: begin
                chan_d   = rev_load_in;
                center_d = total_rev;  // RULE16
            end
            PLDC_SHOW_TGT: begin
                chan_d   = {tgt_q[3], tgt_q[2], tgt_q[1], tgt_q[0]};
                center_d = total_tgt;  // RULE17
            end
            PLDC_SHOW_RATE: center_d = 18'(rate_q);  // RULE14
            PLDC_SHOW_TOTAL: center_d = total_peak;
        endcase
    end

    // Registered outputs
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            center_q <= 18'h00000;
            chan_q   <= 64'h0;
            lamps_q  <= 36'h0;
            stop_q   <= 1'b0;
            preset_q <= 1'b0;
        end else begin
            center_q <= center_d;
            chan_q   <= multi ? chan_d : 64'h0;  // RULE3
            if (state_q != PLDC_ST_ARMED) begin
                lamps_q <= 36'h0;
            end else if (fresh_q) begin
                lamps_q <= {4{`PLDC_LAMP_CENTER}};  // RULE6
            end else begin
                lamps_q <= col_lamps;
            end
            stop_q   <= alarm_q;  // RULE19
            preset_q <= do_reset;  // RULE11
        end
    end

    assign prdata_out       = prdata_q;
    assign pready_out       = pready_q;
    assign pslverr_out      = pslverr_q;
    assign center_meter_out = center_q;
    assign chan_meter_out   = chan_q;
    assign lamps_out        = lamps_q;
    assign machine_stop_out = stop_q;
    assign peak_reset_out   = preset_q;
endmodule : pldc_display_ctrl

// ---- test/pldc_display_ctrl_asserts.sv ----
module pldc_display_ctrl_asserts
    import pldc_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [1:0]  key_pos_in,
    input wire logic        btn_reset_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [35:0] lamps_out,
    input wire logic        peak_reset_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_ready_one_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready held");
    a_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("pready late");
    a_idle_no_ready: assert property (!psel_in |=> !pready_out)
        else $error("pready without request");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr alone");
    a_err_zero_data: assert property (pslverr_out |-> prdata_out == 32'h0)
        else $error("read data on error");
    a_lamps_dark_setup: assert property (key_pos_in == 2'h0 [*7] |-> lamps_out == 36'h0)
        else $error("lamps lit in setup");
    a_reset_blocked: assert property (key_pos_in == 2'h1 [*6] |-> !peak_reset_out)
        else $error("reset accepted while inactive");
    a_reset_taken: assert property ((key_pos_in == 2'h0 && btn_reset_in) [*6]
        |-> peak_reset_out)
        else $error("reset ignored in setup");
endmodule : pldc_display_ctrl_asserts

bind pldc_display_ctrl pldc_display_ctrl_asserts u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .key_pos_in(key_pos_in), .btn_reset_in(btn_reset_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .lamps_out(lamps_out), .peak_reset_out(peak_reset_out));

// ---- test/pldc_load_model.sv ----
// Measurement side: a hit latches new peaks and pulses stroke-complete
module pldc_load_model (
    // Clock
    input  wire logic        core_clk_in,
    // Bench control
    input  wire logic        hit_in,
    input  wire logic [63:0] loads_in,
    // Toward the block
    output logic             stroke_done_out,
    output logic      [63:0] peak_load_out,
    output logic      [63:0] rev_load_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stroke_done_out = 1'b0;
        peak_load_out   = 64'h0;
        rev_load_out    = 64'h0;
    end
    always @(posedge core_clk_in) begin
        stroke_done_out <= hit_in;
        if (hit_in) begin
            peak_load_out <= loads_in;
            rev_load_out  <= {4{16'h0007}};
        end
    end
endmodule : pldc_load_model

// ---- test/press_load_display_control_test.sv ----
module press_load_display_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pldc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hit = 0;
    logic [11:0] pa = 12'h0;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic pready, perr, er, stop, prst, sd;
    logic [1:0] key = 2'h0;
    logic brst = 0, bcap = 0, btol = 0, brate = 0, brev = 0, btgt = 0;
    logic [3:0] bch = 4'h0;
    logic [63:0] ld = {4{16'd100}}, pk, rv, cm;
    logic [17:0] ctr;
    logic [35:0] lamps;
    int fails = 0, n_checks = 0, cyc = 0;

    pldc_load_model u_model (.core_clk_in(clk), .hit_in(hit), .loads_in(ld),
        .stroke_done_out(sd), .peak_load_out(pk), .rev_load_out(rv));
    pldc_display_ctrl dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(pready), .pslverr_out(perr),
        .key_pos_in(key), .btn_reset_in(brst), .btn_cap_in(bcap), .btn_tol_in(btol),
        .btn_rate_in(brate), .btn_rev_in(brev), .btn_tgt_in(btgt), .btn_chan_in(bch),
        .stroke_done_in(sd), .peak_load_in(pk), .rev_load_in(rv),
        .center_meter_out(ctr), .chan_meter_out(cm), .lamps_out(lamps),
        .machine_stop_out(stop), .peak_reset_out(prst));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic s_regs;
        apb(0, 12'h000, 32'h0);
        chk(rd, 36'h0);
        apb(0, 12'h010, 32'h0);
        chk(rd, 36'h0);
        apb(0, 12'hffc, 32'h0);
        chk({er, rd}, 36'h100000000);
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h010 + 12'(4 * i), 32'h42);
        end
        apb(0, 12'h01c, 32'h0);
        chk(rd, 36'h42);
        apb(1, 12'h020, 32'd125);
    endtask : s_regs

    task automatic s_trend;
        hit <= 1'b1;
        tick(1);
        hit <= 1'b0;
        key <= 2'h1;
        tick(8);
        chk(lamps, {4{9'h010}});
        apb(0, 12'h074, 32'h0);
        chk(rd, 36'd100);
        hit <= 1'b1;
        tick(1);
        hit <= 1'b0;
        tick(5);
        chk(lamps, {4{9'h010}});
        chk(ctr, 36'd400);
        chk(stop, 36'h0);
        ld  <= {16'd98, 16'd105, 16'd50, 16'd130};
        hit <= 1'b1;
        tick(1);
        hit <= 1'b0;
        tick(5);
        chk(lamps, {9'h008, 9'h020, 9'h001, 9'h100});
        chk(stop, 36'h1);
    endtask : s_trend

    task automatic s_panel;
        btol <= 1'b1;
        bch  <= 4'h1;
        tick(6);
        chk(ctr, 36'h02010);
        bcap <= 1'b1;
        tick(6);
        chk(ctr, 36'd125);
        btol <= 1'b0;
        bch  <= 4'h0;
        bcap <= 1'b0;
        tick(6);
        chk(ctr, 36'd383);
    endtask : s_panel

    task automatic s_modes;
        apb(1, 12'h000, 32'h3);
        apb(1, 12'h050, 32'd40);
        chk(cm, {16'd98, 16'd105, 16'd50, 16'd130});
        brev <= 1'b1;
        tick(6);
        chk(ctr, 36'd28);
        chk(cm, {4{16'd7}});
        brev <= 1'b0;
        btgt <= 1'b1;
        tick(6);
        chk(ctr, 36'd40);
        btgt  <= 1'b0;
        brate <= 1'b1;
        tick(6);
        // The two monitored hits were six cycles apart
        chk(ctr, 36'(16'(64'd6_000_000_000 / 64'd6)));
        brate <= 1'b0;
    endtask : s_modes

    task automatic s_reset;
        brst <= 1'b1;
        tick(6);
        chk(prst, 36'h0);
        key <= 2'h2;
        tick(6);
        chk(prst, 36'h1);
        key <= 2'h0;
        tick(8);
        chk(lamps, 36'h0);
        chk(prst, 36'h1);
        apb(0, 12'h070, 32'h0);
        chk(rd, 36'h0);
        brst <= 1'b0;
        tick(6);
        chk(prst, 36'h0);
    endtask : s_reset

    initial begin
        tick(8);
        rst <= 1'b0;
        tick(6);
        s_regs();
        s_trend();
        s_panel();
        s_modes();
        s_reset();
        final_report();
    end
endmodule : press_load_display_control_test
